// [logic/wwdog_top.sv]
// Windowed watchdog timer with Avalon-MM register slave
`timescale 1ns/1ps
module wwdog_top
  import wwdog_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST_B,
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        INTERNAL_RC_OSCILLATOR,
  input  wire logic        DEDICATED_WATCHDOG_OSCILLATOR,
  output logic             CHIP_RST_REQ,
  output logic             WDOG_IRQ
);

  // Bus handshake state
  logic              ack_r;        // Second cycle of an access
  logic              req;          // Any request present
  logic              wr_done;      // Write takes effect this edge
  logic              rd_first;     // First cycle of a read
  logic [31:0]       rdata_nxt;    // Read mux output

  // Register contents
  wwdog_mode_s       mode_r;       // Enable, action, tick select
  logic [23:0]       reload_r;     // Reload value
  logic [23:0]       warn_r;       // Warning compare point
  logic [23:0]       window_r;     // Window upper limit
  logic              tof_r;        // Watchdog event flag
  logic              warnf_r;      // Warning flag
  logic              feederr_r;    // Wrong feed flag
  logic              wdrst_r;      // Watchdog caused last reset

  // Counter path
  logic [WWDOG_CW-1:0] count_r;    // Down-counter
  logic [1:0]        pre_r;        // Prescaler phase
  logic              rc_rise;      // Synchronised internal RC tick
  logic              osc_rise;     // Synchronised dedicated osc tick
  logic              tick;         // Selected source tick
  logic              ptick;        // Prescaled tick

  // Feed decode
  wwdog_feed_e       feed_r;       // Feed sequence state
  logic              feed_wr;      // Write to feed port
  logic              feed_ok;      // Correct second key
  logic              feed_bad;     // Wrong feed key while enabled
  logic              win_bad;      // Counter above window limit while enabled
  logic              reload_ev;    // Counter reload event
  logic              timeout_ev;   // Prescaled tick while counter at zero
  logic              fail_ev;      // Time-out or feed failure
  logic              warn_ev;      // Warning point reached
  logic              rst_pend_r;   // Reset request pulse register

  // Byte lane free bus: whole-word writes only
  assign req      = AVS_READ | AVS_WRITE;
  assign wr_done  = AVS_WRITE & ack_r;
  assign rd_first = AVS_READ & ~ack_r;

  // One wait cycle per access so read data comes from a flop
  // Back-to-back requests each still get their own wait cycle
  assign AVS_WAITREQUEST = req & ~ack_r;

  // Access phase tracker
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // Read multiplexer, unmapped offsets read as zero
  always_comb begin
    rdata_nxt = 32'h00000000;
    case (AVS_ADDRESS)
      WWDOG_OFF_MODE: begin
        rdata_nxt[WWDOG_BIT_EN]     = mode_r.en;
        rdata_nxt[WWDOG_BIT_RSTEN]  = mode_r.rsten;
        rdata_nxt[WWDOG_BIT_TOF]    = tof_r;
        rdata_nxt[WWDOG_BIT_WARN]   = warnf_r;
        rdata_nxt[WWDOG_BIT_CLKSEL] = mode_r.clksel;
        rdata_nxt[WWDOG_BIT_FEEDER] = feederr_r;
        rdata_nxt[WWDOG_BIT_WDRST]  = wdrst_r;
      end
      WWDOG_OFF_RELOAD: rdata_nxt[23:0] = reload_r;
      WWDOG_OFF_COUNT:  rdata_nxt[23:0] = count_r;
      WWDOG_OFF_WARN:   rdata_nxt[23:0] = warn_r;
      WWDOG_OFF_WINDOW: rdata_nxt[23:0] = window_r;
      default: begin
        // Feed port and holes read as zero
        rdata_nxt = 32'h00000000;
      end
    endcase
  end

  // Read data captured in the wait cycle, held until next read
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      AVS_READDATA <= 32'h00000000;
    end else if (rd_first) begin
      AVS_READDATA <= rdata_nxt;
    end
  end

  // Tick synchronisers, one per oscillator source
  // Both run all the time so a source switch needs no resync delay
  wwdog_tick_edge u_rc_edge (
    .CLOCK     (CLOCK),
    .RST_B     (RST_B),
    .tick_in   (INTERNAL_RC_OSCILLATOR),
    .tick_rise (rc_rise)
  );

  // Dedicated source keeps ticking when the system clock tree slows
  wwdog_tick_edge u_osc_edge (
    .CLOCK     (CLOCK),
    .RST_B     (RST_B),
    .tick_in   (DEDICATED_WATCHDOG_OSCILLATOR),
    .tick_rise (osc_rise)
  );

  // Source select; switching mid-count may lose one tick
  assign tick  = mode_r.clksel ? osc_rise : rc_rise;
  assign ptick = tick && (pre_r == 2'(WWDOG_PRESCALE - 1));

  // Prescaler divides the selected tick by four
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pre_r <= 2'b00;
    end else if (reload_ev) begin
      pre_r <= 2'b00;
    end else if (tick) begin
      pre_r <= pre_r + 2'b01;
    end
  end

  // Feed decode, taken on the completing write edge
  // Feeds while disabled never fail, so boot code may feed freely
  assign feed_wr  = wr_done && (AVS_ADDRESS == WWDOG_OFF_FEED);
  assign feed_ok  = feed_wr && (feed_r == WWDOG_FEED_ARMED) &&
                    (AVS_WRITEDATA[7:0] == WWDOG_FEED_KEY2);
  // Window limit below reload makes early feeds fail
  assign win_bad  = mode_r.en && (count_r > window_r);
  assign feed_bad = feed_wr && mode_r.en &&
                    ((feed_r == WWDOG_FEED_ARMED) ? !feed_ok :
                     (AVS_WRITEDATA[7:0] != WWDOG_FEED_KEY1));
  assign reload_ev  = feed_ok && !win_bad;
  assign timeout_ev = mode_r.en && ptick &&
                      (count_r == '0) && !reload_ev;
  assign fail_ev    = timeout_ev || feed_bad ||
                      (feed_ok && win_bad);
  assign warn_ev    = mode_r.en && ptick && !reload_ev &&
                      (count_r == warn_r + 24'h000001);

  // Feed sequence state
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      feed_r <= WWDOG_FEED_IDLE;
    end else if (feed_wr) begin
      case (feed_r)
        WWDOG_FEED_IDLE: begin
          // First key arms the sequence
          feed_r <= (AVS_WRITEDATA[7:0] == WWDOG_FEED_KEY1) ?
                    WWDOG_FEED_ARMED : WWDOG_FEED_IDLE;
        end
        WWDOG_FEED_ARMED: begin
          // Second write always ends the sequence
          feed_r <= WWDOG_FEED_IDLE;
        end
        default: begin
          feed_r <= WWDOG_FEED_IDLE;
        end
      endcase
    end
  end

  // Down-counter, reload wins over decrement
  // Parks at zero; the next prescaled tick is the time-out
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      count_r <= WWDOG_RELOAD_RST;
    end else if (reload_ev) begin
      count_r <= reload_r;
    end else if (mode_r.en && ptick && count_r != '0) begin
      count_r <= count_r - 24'h000001;
    end
  end

  // Mode bits: software can only set enable and reset action
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      mode_r <= '0;
    end else begin
      if (fail_ev) begin
        mode_r.en <= 1'b0;
      end else if (wr_done && AVS_ADDRESS == WWDOG_OFF_MODE &&
                   AVS_WRITEDATA[WWDOG_BIT_EN]) begin
        mode_r.en <= 1'b1;
      end
      if (wr_done && AVS_ADDRESS == WWDOG_OFF_MODE) begin
        // Action is sticky so software cannot soften it later
        mode_r.rsten  <= mode_r.rsten | AVS_WRITEDATA[WWDOG_BIT_RSTEN];
        mode_r.clksel <= AVS_WRITEDATA[WWDOG_BIT_CLKSEL];
      end
    end
  end

  // Value registers; reload clamped to the 256-tick minimum
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      reload_r <= WWDOG_RELOAD_RST;
      warn_r   <= WWDOG_WARN_RST;
      window_r <= WWDOG_WINDOW_RST;
    end else if (wr_done) begin
      case (AVS_ADDRESS)
        WWDOG_OFF_RELOAD: begin
          reload_r <= (AVS_WRITEDATA[23:0] < WWDOG_RELOAD_MIN) ?
                      WWDOG_RELOAD_MIN : AVS_WRITEDATA[23:0];
        end
        WWDOG_OFF_WARN:   warn_r   <= AVS_WRITEDATA[23:0];
        WWDOG_OFF_WINDOW: window_r <= AVS_WRITEDATA[23:0];
        default: begin
          // Other offsets hold no value here
          reload_r <= reload_r;
        end
      endcase
    end
  end

  // Sticky flags: hardware set wins over write-one-to-clear
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      tof_r     <= 1'b0;
      warnf_r   <= 1'b0;
      feederr_r <= 1'b0;
    end else begin
      if (fail_ev) begin
        tof_r <= 1'b1;
      end else if (wr_done && AVS_ADDRESS == WWDOG_OFF_MODE &&
                   AVS_WRITEDATA[WWDOG_BIT_TOF]) begin
        tof_r <= 1'b0;
      end
      if (warn_ev) begin
        warnf_r <= 1'b1;
      end else if (wr_done && AVS_ADDRESS == WWDOG_OFF_MODE &&
                   AVS_WRITEDATA[WWDOG_BIT_WARN]) begin
        warnf_r <= 1'b0;
      end
      if (feed_bad || (feed_ok && win_bad)) begin
        feederr_r <= 1'b1;
      end else if (wr_done && AVS_ADDRESS == WWDOG_OFF_MODE &&
                   AVS_WRITEDATA[WWDOG_BIT_FEEDER]) begin
        feederr_r <= 1'b0;
      end
    end
  end

  // Reset-cause flag; cleared by the block's own RST_B (power-on) or by writing one to it
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      wdrst_r <= 1'b0;
    end else if (fail_ev && mode_r.rsten) begin
      wdrst_r <= 1'b1;
    end else if (wr_done && AVS_ADDRESS == WWDOG_OFF_MODE &&
                 AVS_WRITEDATA[WWDOG_BIT_WDRST]) begin
      wdrst_r <= 1'b0;
    end
  end

  // Chip reset request, one clock pulse per failure while reset action is set
  // Must not be looped onto RST_B, or the cause flag is lost
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rst_pend_r <= 1'b0;
    end else begin
      rst_pend_r <= fail_ev && mode_r.rsten;
    end
  end
  assign CHIP_RST_REQ = rst_pend_r;

  // Interrupt level: warning, or failure when reset is not chosen
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      WDOG_IRQ <= 1'b0;
    end else begin
      WDOG_IRQ <= warnf_r | (tof_r & ~mode_r.rsten);
    end
  end

endmodule

// [logic/wwdog_pkg.sv]
// Package of constants and types for the windowed watchdog block
package wwdog_pkg;

  // Register byte offsets
  localparam logic [4:0] WWDOG_OFF_MODE   = 5'h00; // Mode and flags
  localparam logic [4:0] WWDOG_OFF_RELOAD = 5'h04; // Time-out reload value
  localparam logic [4:0] WWDOG_OFF_FEED   = 5'h08; // Feed sequence port
  localparam logic [4:0] WWDOG_OFF_COUNT  = 5'h0c; // Live counter value
  localparam logic [4:0] WWDOG_OFF_WARN   = 5'h10; // Warning compare point
  localparam logic [4:0] WWDOG_OFF_WINDOW = 5'h14; // Window upper limit

  // Mode register bit positions
  localparam int WWDOG_BIT_EN     = 0; // Enable, set only
  localparam int WWDOG_BIT_RSTEN  = 1; // Reset action, set only
  localparam int WWDOG_BIT_TOF    = 2; // Watchdog event flag, w1c
  localparam int WWDOG_BIT_WARN   = 3; // Warning flag, w1c
  localparam int WWDOG_BIT_CLKSEL = 4; // Tick source: 1 = dedicated osc
  localparam int WWDOG_BIT_FEEDER = 5; // Wrong feed flag, w1c
  localparam int WWDOG_BIT_WDRST  = 6; // Last reset was watchdog, w1c

  // Widths and reset values
  localparam int          WWDOG_CW         = 24;        // Counter width
  localparam logic [23:0] WWDOG_RELOAD_RST = 24'hffffff; // Reload reset
  localparam logic [23:0] WWDOG_RELOAD_MIN = 24'h0000ff; // 256 ticks
  localparam logic [23:0] WWDOG_WARN_RST   = 24'h000000; // Warning reset
  localparam logic [23:0] WWDOG_WINDOW_RST = 24'hffffff; // Window open
  localparam int          WWDOG_PRESCALE   = 4;          // Tick divider

  // Feed keys, written in this order
  localparam logic [7:0] WWDOG_FEED_KEY1 = 8'haa;
  localparam logic [7:0] WWDOG_FEED_KEY2 = 8'h55;

  // Software-visible mode bits
  typedef struct packed {
    logic clksel; // Tick source select
    logic rsten;  // Reset instead of interrupt
    logic en;     // Watchdog running
  } wwdog_mode_s;

  // Feed sequence tracker
  typedef enum logic [1:0] {
    WWDOG_FEED_IDLE  = 2'b01,
    WWDOG_FEED_ARMED = 2'b10
  } wwdog_feed_e;

endpackage

// [logic/wwdog_tick_edge.sv]
// Two-flop synchroniser with rising edge detector for an oscillator tick
`timescale 1ns/1ps
module wwdog_tick_edge (
  input  wire logic CLOCK,
  input  wire logic RST_B,
  input  wire logic tick_in,
  output logic      tick_rise
);

  logic meta_r;  // First stage, read only by sync_r
  logic sync_r;  // Second stage, safe to use
  logic prev_r;  // Delayed copy for edge detection

  // Synchroniser chain and edge history
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= tick_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // One pulse per source tick; source must be under half of CLOCK
  assign tick_rise = sync_r & ~prev_r;

endmodule

// [tb/wwdog_checker.sv]
// Assertion checker for the watchdog bus slave and its outputs
`timescale 1ns/1ps
module wwdog_checker
  import wwdog_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RST_B,
  input wire logic [4:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        CHIP_RST_REQ,
  input wire logic        WDOG_IRQ
);
  // Read completes at this edge
  wire logic rd_done = AVS_READ && !AVS_WAITREQUEST;
  // Offset outside the map or not word aligned
  wire logic unmapped = (AVS_ADDRESS[1:0] != 2'h0) ||
                        (AVS_ADDRESS > WWDOG_OFF_WINDOW);

  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  // Exactly one wait cycle per request
  chk_wait_one: assert property ($rose(AVS_READ || AVS_WRITE) |->
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("wait not one");
  // No stall without a request
  chk_idle_nowait: assert property (!(AVS_READ || AVS_WRITE) |->
    !AVS_WAITREQUEST) else $error("wait while idle");
  // Read data hold between reads
  chk_rdata_hold: assert property (!AVS_READ |=> $stable(AVS_READDATA))
    else $error("read data moved");
  // Holes in the map read zero
  chk_unmapped_zero: assert property (rd_done && unmapped |->
    AVS_READDATA == 32'h0) else $error("unmapped read not zero");
  // Feed port is write only
  chk_feed_zero: assert property (rd_done &&
    AVS_ADDRESS == WWDOG_OFF_FEED |-> AVS_READDATA == 32'h0)
    else $error("feed read not zero");
  chk_count_width: assert property (rd_done &&
    AVS_ADDRESS == WWDOG_OFF_COUNT |-> AVS_READDATA[31:24] == 8'h0)
    else $error("count wider than 24 bits");
  chk_reload_floor: assert property (rd_done &&
    AVS_ADDRESS == WWDOG_OFF_RELOAD |-> AVS_READDATA[31:24] == 8'h0 &&
    AVS_READDATA[23:0] >= WWDOG_RELOAD_MIN) else $error("reload floor");
  chk_rst_pulse: assert property (CHIP_RST_REQ |=>
    !CHIP_RST_REQ) else $error("reset request longer than one cycle");
  // Only a register write may drop the interrupt
  chk_irq_holds: assert property (WDOG_IRQ && !AVS_WRITE &&
    !$past(AVS_WRITE) |=> WDOG_IRQ) else $error("interrupt dropped");
endmodule

bind wwdog_top wwdog_checker u_wwdog_checker (
  .CLOCK(CLOCK), .RST_B(RST_B), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .CHIP_RST_REQ(CHIP_RST_REQ), .WDOG_IRQ(WDOG_IRQ)
);

// [tb/wwdog_top_test.sv]
// Self-checking testbench for the windowed watchdog top
`timescale 1ns/1ps
module wwdog_top_test;
  import wwdog_pkg::*;
  logic        clk = 1'b0;    // 25 MHz system clock
  logic        rst_b = 1'b0;  // Async reset, low active
  logic        rd = 1'b0;     // Bus read
  logic        wr = 1'b0;     // Bus write
  logic [4:0]  adr = 5'h00;   // Bus offset
  logic [31:0] wd = 32'h0;    // Write data
  logic [31:0] rdat;          // Read data
  logic [31:0] rq;            // Last word read
  logic        wreq;          // Wait request
  logic        crst;          // Chip reset request
  logic        irq;           // Watchdog interrupt
  logic        tick = 1'b0;   // Oscillator tick
  logic        tk_on = 1'b0;  // Tick running
  logic        tk_sel = 1'b0; // 1 routes tick to dedicated osc
  logic        ph = 1'b0;     // Half-rate phase of the tick
  logic [23:0] r;             // Chosen reload
  int          fail_count = 0;
  int          cmp_count = 0;
  int          rst_seen = 0;  // Reset pulses seen
  int          m_rise = 0;    // Model: tick rises sent
  int          m_base = 0;    // Model: rises counted at last reload
  int          m_load = 0;    // Model: value of last reload

  wwdog_top u_wwdog_top (
    .CLOCK(clk), .RST_B(rst_b), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .INTERNAL_RC_OSCILLATOR(tick & ~tk_sel),
    .DEDICATED_WATCHDOG_OSCILLATOR(tick & tk_sel),
    .CHIP_RST_REQ(crst), .WDOG_IRQ(irq)
  );

  // Clock
  initial begin
    forever #20 clk = ~clk;
  end

  // Tick with 2 cycles high and 2 low, so one rise per 4 cycles
  always @(posedge clk) begin
    if (tk_on) begin
      ph <= ~ph;
      if (ph) begin
        tick <= ~tick;
        if (!tick) begin
          m_rise <= m_rise + 1; // Model counts rising ticks
        end
      end
    end
  end

  // Count reset pulses
  always @(posedge clk) begin
    if (crst) begin
      rst_seen <= rst_seen + 1;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Bus cycle; request held until waitrequest is sampled low at an edge
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (n >= 20) begin
      fail_count++;
      stop_test();
    end
    rq = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hffffffff);
    bus(1'b0, a, 32'h0);
    chk(rq & m, e);
  endtask

  // Interrupt level settles two edges after the completing write
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  // Model: expected count from the reload and ticks since then
  function automatic logic [31:0] m_count();
    return 32'(m_load - (m_rise - m_base) / WWDOG_PRESCALE);
  endfunction

  // Model: time-outs due, one per (reload + 1) prescaled ticks
  function automatic logic [31:0] m_resets();
    return 32'((m_rise - m_base) / (WWDOG_PRESCALE * (m_load + 1)));
  endfunction

  task automatic feed();
    bus(1'b1, WWDOG_OFF_FEED, {24'h0, WWDOG_FEED_KEY1});
    bus(1'b1, WWDOG_OFF_FEED, {24'h0, WWDOG_FEED_KEY2});
  endtask

  // Good feed with the model reloaded alongside
  task automatic good_feed(input int v);
    feed();
    m_load = v;
    m_base = m_rise;
  endtask

  // Even n keeps the tick phase; 8 cycles let the synchroniser settle
  task automatic run(input int n);
    tk_on <= 1'b1;
    repeat (n) @(posedge clk);
    tk_on <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard, well above the roughly 4300 cycles of the run
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  initial begin
    void'($urandom(70113));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rchk(WWDOG_OFF_MODE, 32'h0);
    rchk(WWDOG_OFF_RELOAD, {8'h0, WWDOG_RELOAD_RST});
    rchk(WWDOG_OFF_COUNT, 32'hffffff);
    rchk(WWDOG_OFF_WARN, {8'h0, WWDOG_WARN_RST});
    rchk(WWDOG_OFF_WINDOW, {8'h0, WWDOG_WINDOW_RST});
    rchk(5'h18 + 5'($urandom % 8), 32'h0);
    // Too small a reload is raised to the floor
    bus(1'b1, WWDOG_OFF_RELOAD, $urandom % 255);
    rchk(WWDOG_OFF_RELOAD, 32'hff);
    r = 24'h100 + 24'($urandom % 256);
    bus(1'b1, WWDOG_OFF_RELOAD, {8'h0, r});
    bus(1'b1, WWDOG_OFF_WARN, {8'h0, r - 24'h2});
    // Enable cannot be written back to zero
    bus(1'b1, WWDOG_OFF_MODE, 32'h1);
    bus(1'b1, WWDOG_OFF_MODE, 32'h0);
    rchk(WWDOG_OFF_MODE, 32'h1);
    good_feed(int'(r));
    rchk(WWDOG_OFF_COUNT, m_count());
    run(48);
    rchk(WWDOG_OFF_COUNT, m_count());
    irq_chk(1'b1);
    rchk(WWDOG_OFF_MODE, 32'h9);
    bus(1'b1, WWDOG_OFF_MODE, 32'h8);
    rchk(WWDOG_OFF_MODE, 32'h1);
    irq_chk(1'b0);
    // Dedicated oscillator drives the count
    bus(1'b1, WWDOG_OFF_MODE, 32'h11);
    tk_sel <= 1'b1;
    run(32);
    rchk(WWDOG_OFF_COUNT, m_count());
    // Feed above the window limit fails
    bus(1'b1, WWDOG_OFF_WINDOW, {8'h0, r - 24'h8});
    feed();
    irq_chk(1'b1);
    rchk(WWDOG_OFF_MODE, 32'h14, 32'h17);
    bus(1'b1, WWDOG_OFF_MODE, 32'h7c);
    bus(1'b1, WWDOG_OFF_WINDOW, 32'hffffff);
    // Wrong first key without reset action raises the interrupt
    bus(1'b1, WWDOG_OFF_MODE, 32'h11);
    bus(1'b1, WWDOG_OFF_FEED, $urandom % 170);
    irq_chk(1'b1);
    rchk(WWDOG_OFF_MODE, 32'h34, 32'h77);
    bus(1'b1, WWDOG_OFF_MODE, 32'h7c);
    // Shortest time-out, reset action on, internal RC ticks
    bus(1'b1, WWDOG_OFF_RELOAD, 32'h10);
    tk_sel <= 1'b0;
    bus(1'b1, WWDOG_OFF_MODE, 32'h3);
    good_feed(int'(WWDOG_RELOAD_MIN));
    run(4092);
    chk(32'(rst_seen), m_resets());
    run(4);
    chk(32'(rst_seen), m_resets());
    rchk(WWDOG_OFF_MODE, 32'h46, 32'h57);
    // Hardware reset clears reset action, flag and cause
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rchk(WWDOG_OFF_MODE, 32'h0);
    stop_test();
  end
endmodule
